// *** pkg/ccmp_pkg.sv ***
// ccmp_pkg: offsets, field positions, reset values and mode codes of the
// channel 2 compare block; assumes a 16-bit timer core and a 12-bit APB address.
`default_nettype none

package ccmp_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int unsigned CNT_W = 16;
  localparam int unsigned ADDR_W = 12;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] OFS_CTRL1  = 12'h018;
  localparam logic [11:0] OFS_OUTCTL = 12'h020;
  localparam logic [11:0] OFS_CMP2   = 12'h038;
  localparam logic [11:0] OFS_STAT   = 12'h040;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned BIT_CLR   = 15;
  localparam int unsigned MODE_LSB  = 12;
  localparam int unsigned BIT_PE    = 11;
  localparam int unsigned DIR_LSB   = 8;
  localparam int unsigned OBIT_MEN  = 0;
  localparam int unsigned OBIT_MPOL = 1;
  localparam int unsigned OBIT_CEN  = 2;
  localparam int unsigned OBIT_CPOL = 3;
  localparam int unsigned SBIT_REF  = 0;
  localparam int unsigned SBIT_HIT  = 1;
  localparam int unsigned SBIT_DOWN = 2;
  localparam int unsigned SBIT_OUT  = 3;
  localparam int unsigned SCMP_LSB  = 16;

  // ----------------------------------------
  // reset values and codes
  // ----------------------------------------
  localparam logic [15:0] CTRL1_RST  = 16'h0000;
  localparam logic [3:0]  OUTCTL_RST = 4'h0;
  localparam logic [15:0] CMP_RST    = 16'h0000;
  localparam logic [1:0]  DIR_OUTPUT = 2'h0;

  typedef enum logic [2:0] {
    OCM_FREEZE   = 3'b000,
    OCM_SET      = 3'b001,
    OCM_CLEAR    = 3'b010,
    OCM_TOGGLE   = 3'b011,
    OCM_FORCE_LO = 3'b100,
    OCM_FORCE_HI = 3'b101,
    OCM_PWM1     = 3'b110,
    OCM_PWM2     = 3'b111
  } ccmp_mode_t;

endpackage

`default_nettype wire

// *** pkg/ccmp_ref_if.sv ***
// ccmp_ref_if: carries channel 2 settings and counter state from the register
// side to the reference generator, and the reference level back.
`timescale 1ns/1ps
`default_nettype none

interface ccmp_ref_if;
  ccmp_pkg::ccmp_mode_t          mode;
  logic                          clr_en;
  logic                          is_out;
  logic                          etr;
  logic                          cnt_down;
  logic [ccmp_pkg::CNT_W-1:0]    cnt;
  logic [ccmp_pkg::CNT_W-1:0]    cmp;
  logic                          ref_lvl;
  logic                          match;

  modport ctl (output mode, clr_en, is_out, etr, cnt_down, cnt, cmp,
               input ref_lvl, match);
  modport gen (input mode, clr_en, is_out, etr, cnt_down, cnt, cmp,
               output ref_lvl, match);
endinterface

`default_nettype wire

// *** hdl/ccmp_ref_gen.sv ***
// ccmp_ref_gen: builds the channel 2 output reference from mode, counter and
// active compare value; assumes all inputs are already on pclk.
`timescale 1ns/1ps
`default_nettype none

module ccmp_ref_gen (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // settings and counter in, reference out
  ccmp_ref_if.gen   bus
);

  logic ref_q;
  logic ref_d;
  logic gt;
  logic hit;

  // ----------------------------------------
  // next reference level
  // ----------------------------------------
  always_comb begin
    gt    = bus.cnt > bus.cmp;
    hit   = bus.cnt == bus.cmp;
    ref_d = ref_q;
    case (bus.mode)
      ccmp_pkg::OCM_FREEZE:   ref_d = ref_q;
      ccmp_pkg::OCM_SET:      if (hit) ref_d = 1'b1;
      ccmp_pkg::OCM_CLEAR:    if (hit) ref_d = 1'b0;
      ccmp_pkg::OCM_TOGGLE:   if (hit) ref_d = ~ref_q;
      ccmp_pkg::OCM_FORCE_LO: ref_d = 1'b0;
      ccmp_pkg::OCM_FORCE_HI: ref_d = 1'b1;
      ccmp_pkg::OCM_PWM1:     ref_d = bus.cnt_down ? gt : ~gt;
      ccmp_pkg::OCM_PWM2:     ref_d = bus.cnt_down ? ~gt : gt;
      default:                ref_d = ref_q;
    endcase
    // clear has priority over every mode, including the forced ones
    if (bus.clr_en && bus.etr) ref_d = 1'b0;
    // an input channel produces no reference at all
    if (!bus.is_out) ref_d = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
    end
  end

  assign bus.ref_lvl = ref_q;
  assign bus.match   = hit;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic clr_hit;
  assign clr_hit = (bus.clr_en && bus.etr) || !bus.is_out;

  a_freeze_holds: assert property (
    (bus.mode == ccmp_pkg::OCM_FREEZE) && !clr_hit |=> ref_q == $past(ref_q))
    else $error("freeze mode changed the reference");
  a_set_on_match: assert property (
    (bus.mode == ccmp_pkg::OCM_SET) && hit && !clr_hit |=> ref_q)
    else $error("set on match failed");
  a_clear_on_match: assert property (
    (bus.mode == ccmp_pkg::OCM_CLEAR) && hit && !clr_hit |=> !ref_q)
    else $error("clear on match failed");
  a_toggle_on_match: assert property (
    (bus.mode == ccmp_pkg::OCM_TOGGLE) && hit && !clr_hit |=> ref_q != $past(ref_q))
    else $error("toggle on match failed");
  a_force_low: assert property (
    bus.mode == ccmp_pkg::OCM_FORCE_LO |=> !ref_q)
    else $error("forced low not low");
  a_force_high: assert property (
    (bus.mode == ccmp_pkg::OCM_FORCE_HI) && !clr_hit |=> ref_q)
    else $error("forced high not high");
  a_pwm_one: assert property (
    (bus.mode == ccmp_pkg::OCM_PWM1) && !clr_hit
    |=> ref_q == ($past(bus.cnt_down) == ($past(bus.cnt) > $past(bus.cmp))))
    else $error("pwm mode 1 level wrong");
  a_pwm_two: assert property (
    (bus.mode == ccmp_pkg::OCM_PWM2) && !clr_hit
    |=> ref_q == ($past(bus.cnt_down) != ($past(bus.cnt) > $past(bus.cmp))))
    else $error("pwm mode 2 level wrong");
  a_ext_clear: assert property (
    (bus.clr_en && bus.etr) [*2] |=> !ref_q)
    else $error("external clear ignored");
  a_input_quiet: assert property (
    !bus.is_out |=> !ref_q)
    else $error("reference active on input channel");

  c_pwm_rise: cover property (
    bus.mode == ccmp_pkg::OCM_PWM1 ##1 $rose(ref_q));
  c_ext_clear: cover property (bus.clr_en && bus.etr && ref_q ##1 !ref_q);
  c_toggle: cover property (bus.mode == ccmp_pkg::OCM_TOGGLE && hit && ref_q);

endmodule // ccmp_ref_gen

`default_nettype wire

// *** hdl/ccmp_top.sv ***
// ccmp_top: APB register front and output stage of the channel 2 compare
// logic; assumes counter, direction, update event and filtered trigger come
// from timer logic clocked by pclk.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - direction field decides whether channel works as capture input or compare output
// - control word bits keep position; their meaning follows the channel direction
// - with clear enable set, high filtered trigger forces reference low
// - reference is active high; main and complementary outputs follow polarity bits
// - freeze mode: a counter match leaves the reference unchanged
// - mode 001: reference goes high on counter match
// - mode 010: reference goes low on counter match
// - mode 011: reference inverts on every counter match
// - mode 100: reference held low regardless of counter
// - mode 101: reference held high regardless of counter
// - pwm 1: up inactive above compare, down active above compare
// - pwm 2: up active above compare, down inactive above compare
// - with preload on, software writes and compare register reads reach only preload copy; status shows the active copy
// - with preload on, update event copies preload into active compare
// - preload off disables buffering; control fields reset to zero
// - with preload off a compare write acts on the comparison at once
// - direction code 00 makes channel 2 an output with compare fields live
module ccmp_top (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ccmp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // timer core
  input  wire logic [ccmp_pkg::CNT_W-1:0] core_counter,
  input  wire logic                       counter_down,
  input  wire logic                       update_event,
  input  wire logic                       filtered_external_trigger,
  // channel 2 outputs
  output logic                            ch2_output_reference,
  output logic                            ch2_main_output,
  output logic                            ch2_complementary_output
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [3:0]  outctl_q;
  logic [3:0]  outctl_d;
  logic [15:0] cmp_pre_q;
  logic [15:0] cmp_pre_d;
  logic [15:0] cmp_act_q;
  logic [15:0] cmp_act_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        main_q;
  logic        main_d;
  logic        comp_q;
  logic        comp_d;

  // ----------------------------------------
  // decoded fields
  // ----------------------------------------
  logic        clr_en;
  logic [2:0]  mode_raw;
  logic        pe;
  logic [1:0]  dir;
  logic        is_out;
  logic        men;
  logic        mpol;
  logic        cen;
  logic        cpol;

  // the same bit positions carry filter and prescaler codes in input mode;
  // they are stored untouched and only read as compare fields when is_out, except pe, which sets compare buffering in either direction
  assign clr_en   = ctrl_q[ccmp_pkg::BIT_CLR];
  assign mode_raw = ctrl_q[ccmp_pkg::MODE_LSB +: 3];
  assign pe       = ctrl_q[ccmp_pkg::BIT_PE];
  assign dir      = ctrl_q[ccmp_pkg::DIR_LSB +: 2];
  assign is_out   = dir == ccmp_pkg::DIR_OUTPUT;
  assign men      = outctl_q[ccmp_pkg::OBIT_MEN];
  assign mpol     = outctl_q[ccmp_pkg::OBIT_MPOL];
  assign cen      = outctl_q[ccmp_pkg::OBIT_CEN];
  assign cpol     = outctl_q[ccmp_pkg::OBIT_CPOL];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic acc;
  logic setup_rd;
  logic hit_ctrl;
  logic hit_outctl;
  logic hit_cmp;
  logic hit_stat;
  logic mapped;
  logic wr_ctrl;
  logic wr_outctl;
  logic wr_cmp;

  assign acc        = psel && penable;
  assign setup_rd   = psel && !penable && !pwrite;
  assign hit_ctrl   = paddr == ccmp_pkg::OFS_CTRL1;
  assign hit_outctl = paddr == ccmp_pkg::OFS_OUTCTL;
  assign hit_cmp    = paddr == ccmp_pkg::OFS_CMP2;
  assign hit_stat   = paddr == ccmp_pkg::OFS_STAT;
  assign mapped     = hit_ctrl || hit_outctl || hit_cmp || hit_stat;
  assign wr_ctrl    = acc && pwrite && hit_ctrl;
  assign wr_outctl  = acc && pwrite && hit_outctl;
  assign wr_cmp     = acc && pwrite && hit_cmp;

  // no wait states: the answer is ready in the access cycle because read
  // data is captured during setup
  assign pready  = acc;
  assign pslverr = acc && !mapped;
  assign prdata  = prdata_q;

  // byte-lane merge of the low half word
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) r[7:0] = wd[7:0];
    if (st[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  // ----------------------------------------
  // reference generator
  // ----------------------------------------
  ccmp_ref_if rif ();

  assign rif.mode     = ccmp_pkg::ccmp_mode_t'(mode_raw);
  assign rif.clr_en   = clr_en;
  assign rif.is_out   = is_out;
  assign rif.etr      = filtered_external_trigger;
  assign rif.cnt_down = counter_down;
  assign rif.cnt      = core_counter;
  assign rif.cmp      = cmp_act_q;

  ccmp_ref_gen u_ref_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (rif.gen)
  );

  assign ch2_output_reference = rif.ref_lvl;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_comb begin
    ctrl_d   = ctrl_q;
    outctl_d = outctl_q;
    if (wr_ctrl) begin
      ctrl_d = merge16(ctrl_q, pwdata[15:0], pstrb[1:0]);
    end
    if (wr_outctl && pstrb[0]) begin
      outctl_d = pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= ccmp_pkg::CTRL1_RST;
      outctl_q <= ccmp_pkg::OUTCTL_RST;
    end else begin
      ctrl_q   <= ctrl_d;
      outctl_q <= outctl_d;
    end
  end

  // ----------------------------------------
  // compare register, preload and active copy
  // ----------------------------------------
  logic [15:0] cmp_wr;

  always_comb begin
    cmp_wr    = merge16(cmp_pre_q, pwdata[15:0], pstrb[1:0]);
    cmp_pre_d = cmp_pre_q;
    cmp_act_d = cmp_act_q;
    if (pe) begin
      // buffered: software only touches the preload copy
      if (wr_cmp) cmp_pre_d = cmp_wr;
      if (update_event) cmp_act_d = cmp_pre_q;
    end else begin
      // unbuffered: both copies follow the write at once
      if (wr_cmp) begin
        cmp_pre_d = cmp_wr;
        cmp_act_d = cmp_wr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_pre_q <= ccmp_pkg::CMP_RST;
      cmp_act_q <= ccmp_pkg::CMP_RST;
    end else begin
      cmp_pre_q <= cmp_pre_d;
      cmp_act_q <= cmp_act_d;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    prdata_d = prdata_q;
    if (setup_rd) begin
      prdata_d = 32'h0000_0000;
      if (hit_ctrl) prdata_d[15:0] = ctrl_q;
      if (hit_outctl) prdata_d[3:0] = outctl_q;
      // preload copy is what software sees; equals active copy when unbuffered
      if (hit_cmp) prdata_d[15:0] = cmp_pre_q;
      if (hit_stat) begin
        prdata_d[ccmp_pkg::SBIT_REF]      = rif.ref_lvl;
        prdata_d[ccmp_pkg::SBIT_HIT]      = rif.match;
        prdata_d[ccmp_pkg::SBIT_DOWN]     = counter_down;
        prdata_d[ccmp_pkg::SBIT_OUT]      = is_out;
        prdata_d[ccmp_pkg::SCMP_LSB +: 16] = cmp_act_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------
  // output stage
  // ----------------------------------------
  // the complementary output carries the inverted reference; a disabled
  // output rests at 0 so it cannot glitch through the polarity change
  always_comb begin
    main_d = men && (rif.ref_lvl ^ mpol);
    comp_d = cen && (!rif.ref_lvl ^ cpol);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_q <= 1'b0;
      comp_q <= 1'b0;
    end else begin
      main_q <= main_d;
      comp_q <= comp_d;
    end
  end

  assign ch2_main_output          = main_q;
  assign ch2_complementary_output = comp_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_direct_write: assert property (
    wr_cmp && !pe && (pstrb[1:0] == 2'h3) |=> cmp_act_q == $past(pwdata[15:0]))
    else $error("unbuffered compare write not active");
  a_preload_load: assert property (
    pe && update_event |=> cmp_act_q == $past(cmp_pre_q))
    else $error("update did not load preload value");
  a_preload_hold: assert property (
    pe && !update_event |=> cmp_act_q == $past(cmp_act_q))
    else $error("active compare changed without update");
  a_read_preload: assert property (
    setup_rd && hit_cmp ##1 acc |-> prdata[15:0] == $past(cmp_pre_q))
    else $error("compare read not from preload copy");
  a_main_polarity: assert property (
    men |=> main_q == ($past(rif.ref_lvl) ^ $past(mpol)))
    else $error("main output polarity wrong");
  a_comp_polarity: assert property (
    cen |=> comp_q == (!$past(rif.ref_lvl) ^ $past(cpol)))
    else $error("complementary output polarity wrong");
  a_unmapped_err: assert property (
    acc && !mapped |-> pslverr && pready)
    else $error("unmapped access not flagged");

  c_preload_update: cover property (pe && update_event && cmp_pre_q != cmp_act_q);
  c_direct_write: cover property (wr_cmp && !pe);

endmodule // ccmp_top

`default_nettype wire

// *** sim/testbench.sv ***
// testbench: self-checking bench for the channel 2 compare block with a cycle
// model of reference, outputs and registers; assumes ccmp_top on one pclk.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  logic                          pclk;
  logic                          presetn;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [ccmp_pkg::ADDR_W-1:0]   paddr;
  logic [31:0]                   pwdata;
  logic [3:0]                    pstrb;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  logic [ccmp_pkg::CNT_W-1:0]    core_counter;
  logic                          counter_down;
  logic                          update_event;
  logic                          etr;
  logic                          out_ref;
  logic                          out_main;
  logic                          out_comp;
  int                            miscompares;
  int                            compares;
  integer                        seed;
  logic                          run;
  logic                          upd_on;
  logic [15:0]                   m_ctrl;
  logic [3:0]                    m_oc;
  logic [15:0]                   m_pre;
  logic [15:0]                   m_act;
  logic                          m_ref;
  logic                          m_main;
  logic                          m_comp;
  logic                          gt;
  logic                          hit;
  logic [31:0]                   exp_rd;
  logic                          exp_err;
  logic [15:0]                   w;

  ccmp_top dut (
    .pclk                      (pclk),
    .presetn                   (presetn),
    .psel                      (psel),
    .penable                   (penable),
    .pwrite                    (pwrite),
    .paddr                     (paddr),
    .pwdata                    (pwdata),
    .pstrb                     (pstrb),
    .prdata                    (prdata),
    .pready                    (pready),
    .pslverr                   (pslverr),
    .core_counter              (core_counter),
    .counter_down              (counter_down),
    .update_event              (update_event),
    .filtered_external_trigger (etr),
    .ch2_output_reference      (out_ref),
    .ch2_main_output           (out_main),
    .ch2_complementary_output  (out_comp)
  );

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  // ----------------------------------------
  // compare, bus and closing tasks
  // ----------------------------------------
  task automatic chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // idle cycle between transfers keeps setup capture and model apart
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk_bit(pready, 1'b1, "pready");
    chk_bit(pslverr, exp_err, "pslverr");
    if (!wr) chk_word(prdata, exp_rd, "read data");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // reset values of every register, plus one unmapped offset
  task automatic read_all;
    apb(1'b0, ccmp_pkg::OFS_CTRL1, 0);
    apb(1'b0, ccmp_pkg::OFS_OUTCTL, 0);
    apb(1'b0, ccmp_pkg::OFS_CMP2, 0);
    apb(1'b0, ccmp_pkg::OFS_STAT, 0);
    apb(1'b0, 12'h030, 0);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // cycle model, compared at every edge
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_ctrl = 16'h0000;
      m_oc = 4'h0;
      m_pre = 16'h0000;
      m_act = 16'h0000;
      m_ref = 1'b0;
      m_main = 1'b0;
      m_comp = 1'b0;
    end else begin
      chk_bit(out_ref, m_ref, "reference");
      chk_bit(out_main, m_main, "main output");
      chk_bit(out_comp, m_comp, "complementary output");
      gt = core_counter > m_act;
      hit = core_counter == m_act;
      if (psel && !penable) begin
        exp_err = !(paddr inside {ccmp_pkg::OFS_CTRL1, ccmp_pkg::OFS_OUTCTL,
                                  ccmp_pkg::OFS_CMP2, ccmp_pkg::OFS_STAT});
        case (paddr)
          ccmp_pkg::OFS_CTRL1:  exp_rd = {16'h0000, m_ctrl};
          ccmp_pkg::OFS_OUTCTL: exp_rd = {28'h0000000, m_oc};
          ccmp_pkg::OFS_CMP2:   exp_rd = {16'h0000, m_pre};
          ccmp_pkg::OFS_STAT:   exp_rd = {m_act, 12'h000, m_ctrl[9:8] == 2'h0,
                                          counter_down, hit, m_ref};
          default:              exp_rd = 32'h00000000;
        endcase
      end
      m_main = m_oc[0] & (m_ref ^ m_oc[1]);
      m_comp = m_oc[2] & (~m_ref ^ m_oc[3]);
      if (m_ctrl[9:8] != 2'h0) m_ref = 1'b0;
      else if (m_ctrl[15] && etr) m_ref = 1'b0;
      else begin
        case (m_ctrl[14:12])
          3'h1: m_ref = m_ref | hit;
          3'h2: m_ref = m_ref & ~hit;
          3'h3: m_ref = m_ref ^ hit;
          3'h4: m_ref = 1'b0;
          3'h5: m_ref = 1'b1;
          3'h6: m_ref = counter_down ? gt : ~gt;
          3'h7: m_ref = counter_down ? ~gt : gt;
          default: m_ref = m_ref;
        endcase
      end
      if (update_event && m_ctrl[11]) m_act = m_pre;
      if (psel && penable && pwrite) begin
        case (paddr)
          ccmp_pkg::OFS_CTRL1: begin
            if (pstrb[0]) m_ctrl[7:0] = pwdata[7:0];
            if (pstrb[1]) m_ctrl[15:8] = pwdata[15:8];
          end
          ccmp_pkg::OFS_OUTCTL: if (pstrb[0]) m_oc = pwdata[3:0];
          ccmp_pkg::OFS_CMP2: begin
            if (pstrb[0]) m_pre[7:0] = pwdata[7:0];
            if (pstrb[1]) m_pre[15:8] = pwdata[15:8];
            if (!m_ctrl[11]) m_act = m_pre;
          end
          default: ;
        endcase
      end
    end
  end

  // small counter range makes matches and both pwm sides frequent
  always @(posedge pclk) begin
    if (run) begin
      core_counter <= 16'($random(seed)) & 16'h001F;
      counter_down <= 1'($random(seed));
      etr <= ($random(seed) % 3) == 0;
      update_event <= upd_on & (($random(seed) % 4) == 0);
    end
  end

  initial begin
    #200000;
    miscompares++;
    tally_and_finish;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hD9D27AEA;
    miscompares = 0;
    compares = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    {core_counter, counter_down, update_event, etr, run, upd_on} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 12'h044, 32'h0000FFFF);
    read_all;
    run <= 1'b1;
    for (int k = 0; k < 24; k++) begin
      w = {k / 8 == 1, 3'(k % 8), 1'b0, 1'($random(seed)),
           (k >= 16) ? 2'(1 + k % 3) : 2'h0, 8'($random(seed))};
      apb(1'b1, ccmp_pkg::OFS_CMP2, 32'($random(seed)) & 32'h0000001F);
      apb(1'b1, ccmp_pkg::OFS_OUTCTL, 32'($random(seed)) & 32'h0000000F);
      apb(1'b1, ccmp_pkg::OFS_CTRL1, {16'h0000, w});
      apb(1'b0, ccmp_pkg::OFS_CTRL1, 0);
      repeat (24) @(posedge pclk);
      apb(1'b0, ccmp_pkg::OFS_STAT, 0);
    end
    // mid-run reset: every control and compare field must come back to zero
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    read_all;
    apb(1'b1, ccmp_pkg::OFS_CTRL1, 32'h00006800);
    for (int k = 0; k < 6; k++) begin
      upd_on <= k[0];
      // lane-masked compare writes, including two with no lane at all
      pstrb <= 4'(k % 4);
      apb(1'b1, ccmp_pkg::OFS_CMP2, 32'($random(seed)) & 32'h0000001F);
      apb(1'b0, ccmp_pkg::OFS_CMP2, 0);
      apb(1'b0, ccmp_pkg::OFS_STAT, 0);
      repeat (20) @(posedge pclk);
      apb(1'b0, ccmp_pkg::OFS_STAT, 0);
    end
    tally_and_finish;
  end
endmodule // testbench

`default_nettype wire
